/* hw/wlaf_map.vh */
// constants for the adaptive weight low-pass filter
`ifndef WLAF_MAP_VH
`define WLAF_MAP_VH

// sample and data widths
`define WLAF_DATA_W        24
`define WLAF_FRAC_W        12
`define WLAF_ACC_W         36
`define WLAF_SHIFT_W       4
`define WLAF_BW_W          4

// bandwidth codes, lowest first
`define WLAF_BW_0P125      4'h0
`define WLAF_BW_0P25       4'h1
`define WLAF_BW_0P5        4'h2
`define WLAF_BW_1          4'h3
`define WLAF_BW_2          4'h4
`define WLAF_BW_4          4'h5
`define WLAF_BW_8          4'h6
`define WLAF_BW_15         4'h7
`define WLAF_BW_30         4'h8
`define WLAF_BW_50         4'h9
`define WLAF_BW_ADAPT_MAX  4'h2

// smoothing shifts per bandwidth at the nominal sample rate
`define WLAF_SH_0P125      4'hb
`define WLAF_SH_0P25       4'ha
`define WLAF_SH_0P5        4'h9
`define WLAF_SH_1          4'h8
`define WLAF_SH_2          4'h7
`define WLAF_SH_4          4'h6
`define WLAF_SH_8          4'h5
`define WLAF_SH_15         4'h4
`define WLAF_SH_30         4'h3
`define WLAF_SH_50         4'h2

// rise times to steady state in ms
`define WLAF_RISE_0P125    7993
`define WLAF_RISE_0P25     3994
`define WLAF_RISE_0P5      1993
`define WLAF_RISE_1        993
`define WLAF_RISE_2        493
`define WLAF_RISE_4        233
`define WLAF_RISE_8        122
`define WLAF_RISE_15       66
`define WLAF_RISE_30       36
`define WLAF_RISE_50       30

// timing
`define WLAF_CLK_HZ        100000000
`define WLAF_SAMPLE_HZ     1600
`define WLAF_WINDOW_MS     100
`define WLAF_RISE_CNT_W    16

// reset values
`define WLAF_RST_ACC       36'h000000000
`define WLAF_RST_DATA      24'h000000
`define WLAF_RST_BW        4'h0

`endif

/* hw/lowpass_stage.v */
// one first-order recursive smoothing stage with selectable shift
`timescale 1ns/1ps
`default_nettype none
`include "wlaf_map.vh"

module lowpass_stage (
    // clock and reset
    input  wire                              clk_sys,
    input  wire                              rst_n,
    // sample in
    input  wire                              in_valid,
    input  wire signed [`WLAF_ACC_W-1:0]     in_data,
    input  wire        [`WLAF_SHIFT_W-1:0]   shift,
    // sample out
    output reg                               out_valid_ff,
    output reg  signed [`WLAF_ACC_W-1:0]     out_data_ff
);

    wire signed [`WLAF_ACC_W:0]   diff;
    wire signed [`WLAF_ACC_W:0]   step;
    reg                           primed_ff;

    assign diff = {in_data[`WLAF_ACC_W-1], in_data} - {out_data_ff[`WLAF_ACC_W-1], out_data_ff};
    assign step = diff >>> shift;

    // preload on the first sample so power-up does not ramp from zero
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            primed_ff    <= 1'b0;
            out_valid_ff <= 1'b0;
            out_data_ff  <= `WLAF_RST_ACC;
        end else begin
            out_valid_ff <= in_valid;
            if (in_valid) begin
                primed_ff <= 1'b1;
                if (!primed_ff)
                    out_data_ff <= in_data;
                else
                    out_data_ff <= out_data_ff + step[`WLAF_ACC_W-1:0];
            end
        end
    end

endmodule
`default_nettype wire

/* hw/weight_lowpass_adaptive_filter.v */
// adaptive low-pass filter for the weight sample stream
`timescale 1ns/1ps
`default_nettype none
`include "wlaf_map.vh"

module weight_lowpass_adaptive_filter #(
    parameter WINDOW_CYCLES = `WLAF_WINDOW_MS * (`WLAF_CLK_HZ / 1000)
) (
    // clock and reset
    input  wire                              clk_sys,
    input  wire                              rst_n,
    // configuration
    input  wire        [`WLAF_BW_W-1:0]      bw_sel,
    input  wire                              adaptive_en,
    input  wire        [`WLAF_DATA_W-1:0]    settle_threshold,
    // raw weight samples
    input  wire                              sample_valid,
    input  wire signed [`WLAF_DATA_W-1:0]    sample_data,
    // filtered weight
    output reg                               filt_valid_ff,
    output reg  signed [`WLAF_DATA_W-1:0]    filt_data_ff,
    // status
    output reg                               wide_active_ff,
    output reg         [`WLAF_BW_W-1:0]      active_bw_ff,
    output reg                               settled_ff
);

    ////////////////////////////////////////////////////////////////////////////////
    // decoding

    // out-of-range codes fall back to the widest setting
    function [`WLAF_BW_W-1:0] clamp_bw;
        input [`WLAF_BW_W-1:0] code;
        begin
            if (code > `WLAF_BW_50)
                clamp_bw = `WLAF_BW_50;
            else
                clamp_bw = code;
        end
    endfunction

    // two cascaded stages at these shifts give the -3 dB points
    function [`WLAF_SHIFT_W-1:0] bw_shift;
        input [`WLAF_BW_W-1:0] code;
        begin
            case (code)
                `WLAF_BW_0P125: bw_shift = `WLAF_SH_0P125;
                `WLAF_BW_0P25:  bw_shift = `WLAF_SH_0P25;
                `WLAF_BW_0P5:   bw_shift = `WLAF_SH_0P5;
                `WLAF_BW_1:     bw_shift = `WLAF_SH_1;
                `WLAF_BW_2:     bw_shift = `WLAF_SH_2;
                `WLAF_BW_4:     bw_shift = `WLAF_SH_4;
                `WLAF_BW_8:     bw_shift = `WLAF_SH_8;
                `WLAF_BW_15:    bw_shift = `WLAF_SH_15;
                `WLAF_BW_30:    bw_shift = `WLAF_SH_30;
                default:        bw_shift = `WLAF_SH_50;
            endcase
        end
    endfunction

    // rise time to steady state, in samples
    function [`WLAF_RISE_CNT_W-1:0] rise_samples;
        input [`WLAF_BW_W-1:0] code;
        integer ms;
        integer samples;
        begin
            case (code)
                `WLAF_BW_0P125: ms = `WLAF_RISE_0P125;
                `WLAF_BW_0P25:  ms = `WLAF_RISE_0P25;
                `WLAF_BW_0P5:   ms = `WLAF_RISE_0P5;
                `WLAF_BW_1:     ms = `WLAF_RISE_1;
                `WLAF_BW_2:     ms = `WLAF_RISE_2;
                `WLAF_BW_4:     ms = `WLAF_RISE_4;
                `WLAF_BW_8:     ms = `WLAF_RISE_8;
                `WLAF_BW_15:    ms = `WLAF_RISE_15;
                `WLAF_BW_30:    ms = `WLAF_RISE_30;
                default:        ms = `WLAF_RISE_50;
            endcase
            samples      = ms * `WLAF_SAMPLE_HZ / 1000;
            rise_samples = samples[`WLAF_RISE_CNT_W-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // 100 ms comparison window

    reg        [31:0]               win_cnt_ff;
    reg                             win_tick_ff;
    reg signed [`WLAF_DATA_W-1:0]   latest_ff;
    reg signed [`WLAF_DATA_W-1:0]   snap_ff;
    wire signed [`WLAF_DATA_W:0]    samp_diff;
    wire       [`WLAF_DATA_W:0]     samp_abs;
    wire                            over_thr;

    // free-running tick; window length counted in clocks, not samples
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            win_cnt_ff  <= 32'h00000000;
            win_tick_ff <= 1'b0;
        end else if (win_cnt_ff == WINDOW_CYCLES - 1) begin
            win_cnt_ff  <= 32'h00000000;
            win_tick_ff <= 1'b1;
        end else begin
            win_cnt_ff  <= win_cnt_ff + 32'h00000001;
            win_tick_ff <= 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            latest_ff <= `WLAF_RST_DATA;
            snap_ff   <= `WLAF_RST_DATA;
        end else begin
            if (sample_valid)
                latest_ff <= sample_data;
            if (win_tick_ff)
                snap_ff <= latest_ff;
        end
    end

    assign samp_diff = {latest_ff[`WLAF_DATA_W-1], latest_ff} - {snap_ff[`WLAF_DATA_W-1], snap_ff};
    // both loading and unloading count as change
    assign samp_abs  = samp_diff[`WLAF_DATA_W] ? -samp_diff : samp_diff;
    assign over_thr  = samp_abs > {1'b0, settle_threshold};

    ////////////////////////////////////////////////////////////////////////////////
    // bandwidth choice

    wire [`WLAF_BW_W-1:0] sel_bw;
    wire                  adapt_ok;
    reg  [`WLAF_BW_W-1:0] nxt_active_bw;

    assign sel_bw   = clamp_bw(bw_sel);
    // only the three lowest settings may widen
    assign adapt_ok = adaptive_en && (sel_bw <= `WLAF_BW_ADAPT_MAX);

    // decision held for a whole window while adapt_ok stays high; equal to threshold counts as settled
    always @(posedge clk_sys) begin
        if (!rst_n)
            wide_active_ff <= 1'b0;
        else if (!adapt_ok)
            wide_active_ff <= 1'b0;
        else if (win_tick_ff)
            wide_active_ff <= over_thr;
    end

    always @* begin
        if (wide_active_ff && adapt_ok)
            nxt_active_bw = `WLAF_BW_1;
        else
            nxt_active_bw = sel_bw;
    end

    always @(posedge clk_sys) begin
        if (!rst_n)
            active_bw_ff <= `WLAF_RST_BW;
        else
            active_bw_ff <= nxt_active_bw;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // filter core: two cascaded first-order stages

    wire [`WLAF_SHIFT_W-1:0]      cur_shift;
    wire                          stg_valid [0:2];
    wire signed [`WLAF_ACC_W-1:0] stg_data  [0:2];

    assign cur_shift    = bw_shift(active_bw_ff);
    assign stg_valid[0] = sample_valid;
    assign stg_data[0]  = {sample_data, {`WLAF_FRAC_W{1'b0}}};

    // a second pole steepens the roll-off at the cost of one more cycle
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_stage
            lowpass_stage u_stage (
                .clk_sys      (clk_sys),
                .rst_n        (rst_n),
                .in_valid     (stg_valid[gi]),
                .in_data      (stg_data[gi]),
                .shift        (cur_shift),
                .out_valid_ff (stg_valid[gi+1]),
                .out_data_ff  (stg_data[gi+1])
            );
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            filt_valid_ff <= 1'b0;
            filt_data_ff  <= `WLAF_RST_DATA;
        end else begin
            filt_valid_ff <= stg_valid[2];
            if (stg_valid[2])
                filt_data_ff <= stg_data[2][`WLAF_ACC_W-1:`WLAF_FRAC_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // settle indication

    reg [`WLAF_RISE_CNT_W-1:0] rise_cnt_ff;
    wire [`WLAF_RISE_CNT_W-1:0] rise_lim;
    wire                        restart;

    assign rise_lim = rise_samples(active_bw_ff);
    // a bandwidth change or detected motion starts a fresh rise time
    assign restart  = (nxt_active_bw != active_bw_ff) || (win_tick_ff && over_thr);

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rise_cnt_ff <= {`WLAF_RISE_CNT_W{1'b0}};
            settled_ff  <= 1'b0;
        end else if (restart) begin
            rise_cnt_ff <= {`WLAF_RISE_CNT_W{1'b0}};
            settled_ff  <= 1'b0;
        end else if (filt_valid_ff && !settled_ff) begin
            if (rise_cnt_ff >= rise_lim - 16'h0001)
                settled_ff <= 1'b1;
            rise_cnt_ff <= rise_cnt_ff + 16'h0001;
        end
    end

endmodule
`default_nettype wire

/* verification/wlaf_chk.sv */
// assertions on the ports of the adaptive weight low-pass filter
`timescale 1ns/1ps
`default_nettype none
module wlaf_chk (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               rst_n,
    // configuration and samples
    input wire logic [3:0]         bw_sel,
    input wire logic               adaptive_en,
    input wire logic               sample_valid,
    // results
    input wire logic               filt_valid_ff,
    input wire logic signed [23:0] filt_data_ff,
    input wire logic               wide_active_ff,
    input wire logic [3:0]         active_bw_ff,
    input wire logic               settled_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    property p_lat; sample_valid |-> ##3 filt_valid_ff; endproperty
    property p_cause; filt_valid_ff |-> $past(sample_valid, 3); endproperty
    property p_hold; $past(rst_n) && !filt_valid_ff |-> $stable(filt_data_ff); endproperty
    property p_narrow; !adaptive_en || bw_sel > 4'h2 |=> !wide_active_ff; endproperty
    property p_wide_bw; wide_active_ff |=> active_bw_ff == 4'h3; endproperty
    property p_sel_bw;
        $past(rst_n) && !wide_active_ff |=>
            active_bw_ff == ($past(bw_sel) > 4'h9 ? 4'h9 : $past(bw_sel));
    endproperty
    property p_rose_wide; $rose(wide_active_ff) |-> $past(adaptive_en && bw_sel <= 4'h2);
    endproperty
    // wide mode is decided once per window, so with bw_sel and adaptive_en stable it cannot drop between ticks
    property p_wide_hold;
        $rose(wide_active_ff) ##1 ($stable(bw_sel) && $stable(adaptive_en))[*8]
            |-> wide_active_ff;
    endproperty
    property p_restart; $past(rst_n) && $changed(active_bw_ff) |=> !settled_ff; endproperty
    ////////////////////////////////////////////////////////////////
    a_lat: assert property (p_lat) else $error("output not 3 cycles after sample");
    a_cause: assert property (p_cause) else $error("output without sample");
    a_hold: assert property (p_hold) else $error("data moved without valid");
    a_narrow: assert property (p_narrow) else $error("widening not allowed");
    a_wide_bw: assert property (p_wide_bw) else $error("wide but not 1 Hz");
    a_sel_bw: assert property (p_sel_bw) else $error("selected bandwidth not used");
    a_rose_wide: assert property (p_rose_wide) else $error("bad widening");
    a_wide_hold: assert property (p_wide_hold) else $error("wide dropped early");
    a_restart: assert property (p_restart) else $error("settled kept on change");
    c_out: cover property (filt_valid_ff);
    c_wide: cover property ($rose(wide_active_ff));
    c_settle: cover property ($rose(settled_ff));
endmodule
bind weight_lowpass_adaptive_filter wlaf_chk wlaf_chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .bw_sel(bw_sel), .adaptive_en(adaptive_en),
    .sample_valid(sample_valid), .filt_valid_ff(filt_valid_ff), .filt_data_ff(filt_data_ff),
    .wide_active_ff(wide_active_ff), .active_bw_ff(active_bw_ff), .settled_ff(settled_ff));
`default_nettype wire

/* verification/load_cell_src.sv */
// load cell sample source feeding the filter
`timescale 1ns/1ps
`default_nettype none
module load_cell_src #(
    parameter GAP = 4
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // requested weight
    input  wire logic signed [23:0] level,
    // sample stream
    output logic                    sample_valid,
    output logic signed [23:0]      sample_data
);
    logic               run_ff;
    logic [7:0]         cnt;
    logic signed [23:0] level_ff;
    // level is taken on the rising edge, away from the bench's falling-edge updates
    always @(posedge clk_sys) begin
        run_ff   <= rst_n;
        level_ff <= level;
    end
    // idle data is inverted so a stale value never passes for a sample
    always @(negedge clk_sys) begin
        cnt <= (run_ff && cnt != GAP - 1) ? cnt + 8'h01 : 8'h00;
        sample_valid <= run_ff && cnt == 8'h00;
        sample_data <= (run_ff && cnt == 8'h00) ? level_ff : ~level_ff;
    end
endmodule
`default_nettype wire

/* verification/weight_lowpass_adaptive_filter_tb_top.sv */
// self-checking testbench for the adaptive weight low-pass filter
`timescale 1ns/1ps
`default_nettype none
module weight_lowpass_adaptive_filter_tb_top;
    localparam WIN = 200;
    logic clk_sys, rst_n, adaptive_en, sample_valid, filt_valid_ff, wide_active_ff, settled_ff;
    logic        [3:0]  bw_sel, active_bw_ff;
    logic        [23:0] settle_threshold;
    logic signed [23:0] level, sample_data, filt_data_ff;
    integer             mismatches, tests_run, i;
    weight_lowpass_adaptive_filter #(.WINDOW_CYCLES(WIN)) weight_lowpass_adaptive_filter_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .bw_sel(bw_sel), .adaptive_en(adaptive_en),
        .settle_threshold(settle_threshold), .sample_valid(sample_valid),
        .sample_data(sample_data), .filt_valid_ff(filt_valid_ff), .filt_data_ff(filt_data_ff),
        .wide_active_ff(wide_active_ff), .active_bw_ff(active_bw_ff), .settled_ff(settled_ff));
    load_cell_src #(.GAP(4)) load_cell_src_i (.clk_sys(clk_sys), .rst_n(rst_n), .level(level),
        .sample_valid(sample_valid), .sample_data(sample_data));
    ////////////////////////////////////////////////////////////////
    task cmp_val(input logic [23:0] exp, input logic [23:0] act);
        tests_run = tests_run + 1;
        if (act !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask
    task cmp_bit(input logic exp, input logic act);
        cmp_val({23'h0, exp}, {23'h0, act});
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task t_first;
        i = 0;
        while (filt_valid_ff !== 1'b1 && i < 40) begin
            @(negedge clk_sys);
            i = i + 1;
        end
        cmp_val(level, filt_data_ff);
    endtask
    task settle_case(input logic [3:0] bw, input integer n);
        integer cnt, k, d;
        cnt = 0;
        k = 0;
        bw_sel = bw;
        level = -level;
        repeat (4) @(negedge clk_sys);
        while (settled_ff !== 1'b1 && k < 4 * n + 100) begin
            if (filt_valid_ff === 1'b1) cnt = cnt + 1;
            @(negedge clk_sys);
            k = k + 1;
        end
        cmp_bit(1'b1, cnt >= n - 1 && cnt <= n + 2);
        d = filt_data_ff - level;
        cmp_bit(1'b1, d < 64 && d > -64);
    endtask
    // two window spans cover the widening tick and the tick that ends it
    task adapt_case(input logic [3:0] bw, input logic en, input logic signed [23:0] delta,
                    input logic exp);
        logic seen, wid;
        seen = 1'b0;
        wid = 1'b0;
        bw_sel = bw;
        adaptive_en = en;
        level = level + delta;
        repeat (2 * WIN + 4) begin
            @(negedge clk_sys);
            if (wide_active_ff === 1'b1) seen = 1'b1;
            if (active_bw_ff === 4'h3 && bw !== 4'h3) wid = 1'b1;
        end
        cmp_bit(exp, seen);
        cmp_bit(exp && bw != 4'h3, wid);
        cmp_bit(1'b0, wide_active_ff);
        cmp_val({20'h00000, bw}, {20'h00000, active_bw_ff});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        bw_sel = 4'h0;
        adaptive_en = 1'b0;
        settle_threshold = 24'hffffff;
        level = 24'h000400;
        mismatches = 0;
        tests_run = 0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        t_first;
        for (i = 0; i < 11; i = i + 1) begin
            bw_sel = i;
            repeat (3) @(negedge clk_sys);
            cmp_val((i > 9) ? 24'h000009 : i, {20'h00000, active_bw_ff});
        end
        settle_case(4'h3, 1588);
        settle_case(4'h6, 195);
        settle_case(4'h9, 48);
        settle_threshold = 24'h000064;
        adapt_case(4'h0, 1'b0, 24'sh0001f4, 1'b0);
        adapt_case(4'h0, 1'b1, 24'sh0001f4, 1'b1);
        adapt_case(4'h1, 1'b1, -24'sh0001f4, 1'b1);
        adapt_case(4'h2, 1'b1, 24'sh000064, 1'b0);
        adapt_case(4'h2, 1'b1, 24'sh000065, 1'b1);
        adapt_case(4'h3, 1'b1, 24'sh0001f4, 1'b0);
        adapt_case(4'h9, 1'b1, -24'sh0001f4, 1'b0);
        end_sim;
    end
    initial begin
        #400000;
        mismatches = mismatches + 1;
        end_sim;
    end
endmodule
`default_nettype wire
